/* File: uncorrectable_error_status_mask.sv */
// uncorrectable error status and mask registers of the primary link
`timescale 1ns/1ps
//------------------------------------------------------------
// Function
// - status bits clear only on write-one or fundamental reset
// - bit 20 sets on unsupported request
// - bit 19 sets on end-to-end CRC error
// - bit 18 sets on malformed packet
// - bit 17 sets on receiver overflow
// - bit 16 sets on unexpected completion
// - bit 15 sets on completer abort
// - bit 14 sets on completion time-out
// - bit 13 sets on flow control error
// - bit 12 sets on poisoned packet
// - bit 4 sets on link protocol error
// - reserved bits read zero, ignore writes
// - masked error does not set status
// - masked error sends no error message
// - masked error skips header log, pointer
// - mask bits read-write, reset to zero
// - fundamental reset from resetn, link or global reset
// - status reflects primary link errors only
// - fundamental reset clears all error registers
//------------------------------------------------------------
module uncorrectable_error_status_mask
   import uncorrectable_error_pkg::*;
(
   input  wire logic                                   clk,
   input  wire logic                                   resetn,
   input  wire logic                                   link_reset_n,
   input  wire logic                                   global_reset_n,
   input  wire logic                                   cfg_wr,
   input  wire logic                                   cfg_rd,
   input  wire logic [uncorrectable_error_pkg::ADDR_W-1:0] cfg_addr,
   input  wire logic [3:0]                             cfg_be,
   input  wire logic [uncorrectable_error_pkg::DATA_W-1:0] cfg_wdata,
   output logic      [uncorrectable_error_pkg::DATA_W-1:0] cfg_rdata,
   input  wire logic                                   unsupported_request_flag,
   input  wire logic                                   end_to_end_crc_flag,
   input  wire logic                                   malformed_packet_flag,
   input  wire logic                                   receiver_overflow_flag,
   input  wire logic                                   unexpected_completion_flag,
   input  wire logic                                   completer_abort_flag,
   input  wire logic                                   completion_timeout_flag,
   input  wire logic                                   flow_control_protocol_flag,
   input  wire logic                                   poisoned_packet_flag,
   input  wire logic                                   link_protocol_flag,
   output logic      [uncorrectable_error_pkg::DATA_W-1:0] error_report,
   output logic                                        fundamental_reset_n
);
   import uncorrectable_error_pkg::*;

   //------------------------------------------------------------
   // reset and decode
   //------------------------------------------------------------
   logic [DATA_W-1:0] flags_r;
   logic [DATA_W-1:0] flags_nxt;
   logic [DATA_W-1:0] suppress_r;
   logic [DATA_W-1:0] suppress_nxt;
   logic [DATA_W-1:0] raw_err;
   logic [DATA_W-1:0] live_err;
   logic [DATA_W-1:0] byte_mask;
   logic              core_rst_n;
   logic              wr_flags;
   logic              wr_suppress;

   // combined reset: any of the three sources takes the registers down
   assign core_rst_n = resetn & link_reset_n & global_reset_n;
   assign fundamental_reset_n = core_rst_n;

   function automatic logic [DATA_W-1:0] lanes(input logic [3:0] be);
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   assign byte_mask   = lanes(cfg_be);
   assign wr_flags    = cfg_wr && (cfg_addr == FLAGS_OFFSET);
   assign wr_suppress = cfg_wr && (cfg_addr == SUPPRESS_OFFSET);

   //------------------------------------------------------------
   // error event gathering
   //------------------------------------------------------------
   // only primary link detectors are wired in here
   always_comb begin
      raw_err                    = 32'h0000_0000;
      raw_err[BIT_UNSUPPORTED]   = unsupported_request_flag;
      raw_err[BIT_ECRC]          = end_to_end_crc_flag;
      raw_err[BIT_MALFORMED]     = malformed_packet_flag;
      raw_err[BIT_RX_OVERFLOW]   = receiver_overflow_flag;
      raw_err[BIT_UNEXPECTED]    = unexpected_completion_flag;
      raw_err[BIT_ABORT]         = completer_abort_flag;
      raw_err[BIT_TIMEOUT]       = completion_timeout_flag;
      raw_err[BIT_FLOW_CONTROL]  = flow_control_protocol_flag;
      raw_err[BIT_POISONED]      = poisoned_packet_flag;
      raw_err[BIT_LINK_PROTOCOL] = link_protocol_flag;
   end

   // masked errors are dropped here, not held pending
   assign live_err = raw_err & ~suppress_r & IMPL_MASK;

   //------------------------------------------------------------
   // status register
   //------------------------------------------------------------
   always_comb begin
      flags_nxt = flags_r;
      if (wr_flags) begin
         flags_nxt = flags_nxt & ~(cfg_wdata & byte_mask);
      end
      // set applied after clear so a same-cycle event survives
      flags_nxt = (flags_nxt | live_err) & IMPL_MASK;
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   //------------------------------------------------------------
   // mask register
   //------------------------------------------------------------
   always_comb begin
      suppress_nxt = suppress_r;
      if (wr_suppress) begin
         suppress_nxt = ((suppress_r & ~byte_mask) | (cfg_wdata & byte_mask)) & IMPL_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         suppress_r <= SUPPRESS_RESET;
      end else begin
         suppress_r <= suppress_nxt;
      end
   end

   //------------------------------------------------------------
   // reporting and read back
   //------------------------------------------------------------
   // one-cycle report strobe gating messages, header log and first-error pointer
   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         error_report <= 32'h0000_0000;
      end else begin
         error_report <= live_err;
      end
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         cfg_rdata <= 32'h0000_0000;
      end else if (cfg_rd) begin
         case (cfg_addr)
            FLAGS_OFFSET:    cfg_rdata <= flags_r;
            SUPPRESS_OFFSET: cfg_rdata <= suppress_r;
            default:         cfg_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

/* File: uncorrectable_error_pkg.sv */
// package: offsets, field positions and reset values of the uncorrectable error registers
package uncorrectable_error_pkg;
   localparam int          ADDR_W            = 12;
   localparam int          DATA_W            = 32;
   localparam logic [11:0] FLAGS_OFFSET      = 12'h104;
   localparam logic [11:0] SUPPRESS_OFFSET   = 12'h108;
   localparam logic [31:0] FLAGS_RESET       = 32'h0000_0000;
   localparam logic [31:0] SUPPRESS_RESET    = 32'h0000_0000;
   // bit positions
   localparam int          BIT_UNSUPPORTED   = 20;
   localparam int          BIT_ECRC          = 19;
   localparam int          BIT_MALFORMED     = 18;
   localparam int          BIT_RX_OVERFLOW   = 17;
   localparam int          BIT_UNEXPECTED    = 16;
   localparam int          BIT_ABORT         = 15;
   localparam int          BIT_TIMEOUT       = 14;
   localparam int          BIT_FLOW_CONTROL  = 13;
   localparam int          BIT_POISONED      = 12;
   localparam int          BIT_LINK_PROTOCOL = 4;
   // implemented bits: 20:12 and 4, everything else reserved
   localparam logic [31:0] IMPL_MASK         = 32'h001F_F010;
   localparam int          NUM_ERR           = 10;
endpackage

/* File: ue_status_sva.sv */
// assertions for the uncorrectable error status and mask block
`timescale 1ns/1ps
module ue_chk
   import uncorrectable_error_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        link_reset_n,
   input wire logic        global_reset_n,
   input wire logic        cfg_wr,
   input wire logic        cfg_rd,
   input wire logic [11:0] cfg_addr,
   input wire logic [3:0]  cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic [31:0] cfg_rdata,
   input wire logic [31:0] error_report,
   input wire logic        unsupported_request_flag,
   input wire logic        link_protocol_flag,
   input wire logic        fundamental_reset_n
);
   logic rst_n;
   assign rst_n = resetn & link_reset_n & global_reset_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rd_s;
      cfg_rd && cfg_addr == FLAGS_OFFSET;
   endsequence
   // no new event in the clear cycle, so the clear must win
   sequence clr_s;
      cfg_wr && cfg_addr == FLAGS_OFFSET && cfg_be[2] && cfg_wdata[20]
         && !unsupported_request_flag;
   endsequence
   rst_join_a: assert property (disable iff (1'b0) fundamental_reset_n == rst_n)
      else $error("reset join wrong");
   ur_cause_a: assert property (error_report[20] |-> $past(unsupported_request_flag))
      else $error("report without event");
   dl_cause_a: assert property (error_report[4] |-> $past(link_protocol_flag))
      else $error("link report without event");
   seen_read_a: assert property (error_report[20] ##0 rd_s |=> cfg_rdata[20])
      else $error("status not set");
   clear_read_a: assert property (clr_s ##1 rd_s |=> !cfg_rdata[20])
      else $error("status not cleared");
   rsv_read_a: assert property ((cfg_rdata & ~IMPL_MASK) == '0)
      else $error("reserved read bit high");
   rsv_report_a: assert property ((error_report & ~IMPL_MASK) == '0)
      else $error("reserved report bit high");
   unmapped_a: assert property (cfg_rd && cfg_addr != FLAGS_OFFSET
      && cfg_addr != SUPPRESS_OFFSET |=> cfg_rdata == '0)
      else $error("unmapped read not zero");
endmodule
bind uncorrectable_error_status_mask ue_chk chk (.*);

/* File: link_partner.sv */
// upstream link model: raises one error strobe per event bit
`timescale 1ns/1ps
module link_partner (
   input  wire logic [31:0] e,
   output logic      [9:0]  f
);
   // strobes follow the status layout: bits 20 down to 12, then 4
   assign f = {e[20:12], e[4]};
endmodule

/* File: testbench.sv */
// register-level testbench for the uncorrectable error block
`timescale 1ns/1ps
module testbench;
   import uncorrectable_error_pkg::*;
   logic clk = 0, resetn = 0, link_reset_n = 1, global_reset_n = 1, cfg_wr = 0, cfg_rd = 0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0]  cfg_be = 4'h0;
   logic [31:0] cfg_wdata = '0, e = '0, b, cfg_rdata, error_report;
   logic [9:0]  f;
   logic        fundamental_reset_n;
   int          error_cnt = 0, cmp_count = 0;
   always #12.5 clk = ~clk;
   link_partner lp (.e(e), .f(f));
   uncorrectable_error_status_mask DUT (.*, .unsupported_request_flag(f[9]),
      .end_to_end_crc_flag(f[8]), .malformed_packet_flag(f[7]),
      .receiver_overflow_flag(f[6]), .unexpected_completion_flag(f[5]),
      .completer_abort_flag(f[4]), .completion_timeout_flag(f[3]),
      .flow_control_protocol_flag(f[2]), .poisoned_packet_flag(f[1]),
      .link_protocol_flag(f[0]));
   // one access per cycle; strobes are reassigned, never pulsed, to avoid double drives
   task automatic op(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic [31:0] ev);
      cfg_wr = w;
      cfg_rd = !w;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      e = ev;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      op(0, a, 4'h0, '0, '0);
      cmp_count++;
      if (cfg_rdata !== x) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, cfg_rdata, x);
      end
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] x);
      cmp_count++;
      if (got !== x) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, x);
      end
   endtask
   task automatic results;
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 resetn = 1;
      rd(FLAGS_OFFSET, '0);
      op(1, SUPPRESS_OFFSET, 4'hF, '1, '0);
      rd(SUPPRESS_OFFSET, IMPL_MASK);
      op(1, 12'h10C, 4'hF, '0, IMPL_MASK);
      chk(error_report, '0);
      op(1, SUPPRESS_OFFSET, 4'hF, '0, '0);
      rd(FLAGS_OFFSET, '0);
      for (int p = 0; p < 32; p++) begin
         b = 32'h1 << p;
         if (IMPL_MASK[p]) begin
            op(1, 12'h10C, 4'hF, '0, b);
            chk(error_report, b);
            rd(FLAGS_OFFSET, b);
            op(1, FLAGS_OFFSET, 4'hF, ~b, '0);
            op(1, FLAGS_OFFSET, 4'h0, b, '0);
            rd(FLAGS_OFFSET, b);
            op(1, FLAGS_OFFSET, 4'hF, b, '0);
            rd(FLAGS_OFFSET, '0);
         end
      end
      op(1, FLAGS_OFFSET, 4'hF, '1, IMPL_MASK);
      rd(12'h10C, '0);
      rd(FLAGS_OFFSET, IMPL_MASK);
      op(1, SUPPRESS_OFFSET, 4'h4, '1, '0);
      rd(SUPPRESS_OFFSET, 32'h001F_0000);
      global_reset_n = 0;
      op(1, 12'h000, 4'h0, '0, '0);
      global_reset_n = 1;
      rd(SUPPRESS_OFFSET, '0);
      op(1, 12'h000, 4'h0, '0, IMPL_MASK);
      link_reset_n = 0;
      op(1, 12'h000, 4'h0, '0, '0);
      link_reset_n = 1;
      rd(FLAGS_OFFSET, '0);
      results;
   end
   initial begin
      #20000;
      error_cnt++;
      results;
   end
endmodule
